// [unef_pkg.sv]
// Package: register map, field layout and timing constants for the USB node event flags block
package unef_pkg;

  localparam int unsigned CLK_HZ = 25000000;

  // Byte addresses on the register bus
  localparam logic [7:0] MISC_EVENT_ADDR  = 8'h00;
  localparam logic [7:0] MISC_MASK_ADDR   = 8'h04;
  localparam logic [7:0] TX_EVENT_ADDR    = 8'h08;
  localparam logic [7:0] TX_MASK_ADDR     = 8'h0C;
  localparam logic [7:0] RX_EVENT_ADDR    = 8'h10;
  localparam logic [7:0] RX_MASK_ADDR     = 8'h14;
  localparam logic [7:0] NAK_EVENT_ADDR   = 8'h18;
  localparam logic [7:0] NAK_MASK_ADDR    = 8'h1C;
  localparam logic [7:0] MAIN_EVENT_ADDR  = 8'h20;
  localparam logic [7:0] MAIN_MASK_ADDR   = 8'h24;
  localparam logic [7:0] NODE_STATE_ADDR  = 8'h28;
  localparam logic [7:0] TX_STATUS_ADDR   = 8'h30;
  localparam logic [7:0] RX_STATUS_ADDR   = 8'h40;
  localparam int unsigned ADDR_LSB = 2;

  // Miscellaneous event bit positions
  localparam int unsigned MISC_WAKE   = 1;
  localparam int unsigned MISC_DMA    = 2;
  localparam int unsigned MISC_EOP    = 3;
  localparam int unsigned MISC_SHORT  = 4;
  localparam int unsigned MISC_LONG   = 5;
  localparam int unsigned MISC_RESET  = 6;
  localparam int unsigned MISC_RESUME = 7;
  // Bits cleared by reading the miscellaneous event register
  localparam logic [7:0] MISC_COR_MASK = 8'hF8;

  // Main event bit positions
  localparam int unsigned MAIN_WARN = 0;
  localparam int unsigned MAIN_MISC = 1;
  localparam int unsigned MAIN_TX   = 2;
  localparam int unsigned MAIN_SOF  = 3;
  localparam int unsigned MAIN_NAK  = 4;
  localparam int unsigned MAIN_LOCK = 5;
  localparam int unsigned MAIN_RX   = 6;
  localparam int unsigned MAIN_MIE  = 7;

  localparam int unsigned NUM_EP  = 4;
  localparam int unsigned HI_BASE = 4;

  localparam logic [1:0] NODE_RESET   = 2'h0;
  localparam logic [1:0] NODE_SUSPEND = 2'h3;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Idle and reset detection times
  localparam int unsigned SHORT_IDLE_US  = 3000;
  localparam int unsigned LONG_IDLE_US   = 5000;
  localparam int unsigned SE0_RESET_NS   = 2500;
  localparam int unsigned SHORT_IDLE_CYC = SHORT_IDLE_US * (CLK_HZ / 1000000);
  localparam int unsigned LONG_IDLE_CYC  = LONG_IDLE_US * (CLK_HZ / 1000000);
  localparam int unsigned SE0_RESET_CYC  = (SE0_RESET_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned TMR_W = 17;

endpackage

// [unef_idle_timer.sv]
// Bus line-state timers: idle and single-ended-zero duration detection
`timescale 1ns/1ps
module unef_idle_timer
  import unef_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_IDLE_CYC,
  parameter int unsigned LONG_CYC  = LONG_IDLE_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic idle_i,
  input  wire logic se0_i,
  output logic      short_o,
  output logic      long_o,
  output logic      se0_o
);

  logic [TMR_W-1:0] idle_cnt_q;
  logic [7:0]       se0_cnt_q;

  // Saturating counter; pulses fire exactly once per idle stretch
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_cnt_q <= '0;
    end else if (!idle_i) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q < TMR_W'(LONG_CYC)) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      se0_cnt_q <= '0;
    end else if (!se0_i) begin
      se0_cnt_q <= '0;
    end else if (se0_cnt_q < 8'(SE0_RESET_CYC)) begin
      se0_cnt_q <= se0_cnt_q + 1'b1;
    end
  end

  assign short_o = idle_i && (idle_cnt_q == TMR_W'(SHORT_CYC - 1));
  assign long_o  = idle_i && (idle_cnt_q == TMR_W'(LONG_CYC - 1));
  assign se0_o   = se0_i && (se0_cnt_q == 8'(SE0_RESET_CYC - 1));

endmodule

// [unef_top.sv]
// Event flag capture, masking and summary logic with an AXI4-Lite register slave
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// (R1) Wake flag follows pending wake bits; clears only when those clear.
// (R2) DMA flag is set while any unmasked DMA event bit is set.
// (R3) End-of-packet flag sets on valid EOP; cleared by event read.
// (R4) Short idle flag sets after 3 ms idle; cleared by read.
// (R5) Long idle flag sets after 5 ms idle; cleared by read.
// (R6) Bus-reset flag sets after 2.5 us of SE0; cleared by read.
// (R7) Firmware holds node in reset at least 100 us after bus reset.
// (R8) In suspend, non-idle bus activity sets resume flag; cleared by read.
// (R9) Firmware alone enters suspend or resume by writing node state.
// (R10) Miscellaneous mask bits gate events to miscellaneous summary; reset zero.
// (R11) Transmit-done bits mirror per-endpoint completion; cleared by status read.
// (R12) Underrun bits set on FIFO underflow; cleared by status read.
// (R13) Endpoint 0 underrun bit always reads zero.
// (R14) Transmit mask bits gate transmit summary; reset zero.
// (R15) Receive-done bits set on error or last byte; status read clears.
// (R16) Endpoint 0 receive-done reflects only good packet completion.
// (R17) Firmware checks receive error status on streaming endpoints.
// (R18) Overrun bits set on receive FIFO overrun; cleared by event read.
// (R19) Receive mask bits gate receive summary; reset zero.
// (R20) IN NAK bits set for enabled address and endpoint; read clears.
// (R21) OUT NAK bits set likewise, except overrun-caused NAKs; read clears.
// (R22) NAK mask bits gate NAK summary; reset zero.
// (R23) Miscellaneous summary sets on unmasked event; cleared by event read.
// (R24) NAK summary clears when NAK event register is read.
// (R25) Main mask bit 7 is master enable gating the interrupt output.
// (R26) Event capture ignores masks; masks only gate summaries.
module unef_top
  import unef_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_IDLE_CYC,
  parameter int unsigned LONG_CYC  = LONG_IDLE_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        bus_idle_i,
  input  wire logic        bus_se0_i,
  input  wire logic        eop_valid_i,
  input  wire logic        pending_wake_cpu_i,
  input  wire logic        pending_wake_bus_i,
  input  wire logic [7:0]  dma_event_reg_i,
  input  wire logic [7:0]  dma_event_mask_i,
  input  wire logic [3:0]  tx_done_i,
  input  wire logic [3:0]  tx_underflow_i,
  input  wire logic [3:0]  rx_last_i,
  input  wire logic [3:0]  rx_err_i,
  input  wire logic [3:0]  rx_overrun_i,
  input  wire logic [3:0]  nak_in_i,
  input  wire logic [3:0]  nak_out_i,
  input  wire logic [3:0]  nak_out_overrun_i,
  input  wire logic        address_enable_i,
  input  wire logic [3:0]  endpoint_enable_i,
  input  wire logic [2:0]  other_main_events_i,
  output logic [1:0]       node_state_o,
  output logic             interrupt_pin_o
);

  // Bus pins are asynchronous to mclk
  logic [1:0] idle_sync_q;
  logic [1:0] se0_sync_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_sync_q <= 2'h0;
      se0_sync_q  <= 2'h0;
    end else begin
      idle_sync_q <= {idle_sync_q[0], bus_idle_i};
      se0_sync_q  <= {se0_sync_q[0], bus_se0_i};
    end
  end
  logic idle_s;
  logic se0_s;
  assign idle_s = idle_sync_q[1];
  assign se0_s  = se0_sync_q[1];
  logic short_p;
  logic long_p;
  logic se0_p;
  unef_idle_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_timer (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .idle_i  (idle_s),
    .se0_i   (se0_s),
    .short_o (short_p),
    .long_o  (long_p),
    .se0_o   (se0_p)
  );
  logic        aw_held_q;
  logic [7:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        wr_go;
  logic        rd_go;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go = aw_held_q && w_held_q;
  assign rd_go = s_axi_arvalid && !rvalid_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= BYTE_ZERO;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // Register word decode, offsets aligned to 32-bit words
  logic [7:0] wa;
  logic [7:0] ra;
  assign wa = {aw_addr_q[7:ADDR_LSB], 2'h0};
  assign ra = {s_axi_araddr[7:ADDR_LSB], 2'h0};
  logic wr_ok;
  always_comb begin
    case (wa)
      MISC_MASK_ADDR, TX_MASK_ADDR, RX_MASK_ADDR, NAK_MASK_ADDR,
      MAIN_MASK_ADDR, NODE_STATE_ADDR:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end
  logic wr_lane;
  assign wr_lane = wr_go && wr_ok && w_strb_q[0];
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  logic [7:0] misc_mask_q;
  logic [7:0] tx_mask_q;
  logic [7:0] rx_mask_q;
  logic [7:0] nak_mask_q;
  logic [7:0] main_mask_q;
  logic [1:0] node_state_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      misc_mask_q  <= BYTE_ZERO; // [R10] [R14] [R19] [R22]
      tx_mask_q    <= BYTE_ZERO;
      rx_mask_q    <= BYTE_ZERO;
      nak_mask_q   <= BYTE_ZERO;
      main_mask_q  <= BYTE_ZERO;
      node_state_q <= NODE_RESET;
    end else if (wr_lane) begin
      case (wa)
        MISC_MASK_ADDR:  misc_mask_q  <= w_data_q[7:0];
        TX_MASK_ADDR:    tx_mask_q    <= w_data_q[7:0];
        RX_MASK_ADDR:    rx_mask_q    <= w_data_q[7:0];
        NAK_MASK_ADDR:   nak_mask_q   <= w_data_q[7:0];
        MAIN_MASK_ADDR:  main_mask_q  <= w_data_q[7:0];
        NODE_STATE_ADDR: node_state_q <= w_data_q[1:0]; // [R9]
        default:         node_state_q <= node_state_q;
      endcase
    end
  end
  assign node_state_o = node_state_q;

  // Read strobes used as clear-on-read side effects
  logic rd_misc;
  logic rd_rx;
  logic rd_nak;
  logic [3:0] rd_txs;
  logic [3:0] rd_rxs;
  assign rd_misc = rd_go && (ra == MISC_EVENT_ADDR);
  assign rd_rx   = rd_go && (ra == RX_EVENT_ADDR);
  assign rd_nak  = rd_go && (ra == NAK_EVENT_ADDR);
  logic [7:0] misc_q;
  logic [7:0] misc_set;
  logic [7:0] misc_view;
  logic       resume_p;
  assign resume_p = (node_state_q == NODE_SUSPEND) && !idle_s; // [R8]
  always_comb begin
    misc_set = BYTE_ZERO;
    misc_set[MISC_EOP]    = eop_valid_i; // [R3]
    misc_set[MISC_SHORT]  = short_p;     // [R4]
    misc_set[MISC_LONG]   = long_p;      // [R5]
    misc_set[MISC_RESET]  = se0_p;       // [R6]
    misc_set[MISC_RESUME] = resume_p;    // [R8]
  end

  // Set wins over the clearing read in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      misc_q <= BYTE_ZERO;
    end else begin
      misc_q <= ((misc_q & ~(rd_misc ? MISC_COR_MASK : BYTE_ZERO)) | misc_set) & MISC_COR_MASK; // [R26]
    end
  end

  // Wake and DMA flags are live levels, no storage of their own
  always_comb begin
    misc_view = misc_q;
    misc_view[MISC_WAKE] = pending_wake_cpu_i || pending_wake_bus_i; // [R1]
    misc_view[MISC_DMA]  = |(dma_event_reg_i & dma_event_mask_i);    // [R2]
  end
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] nak_q;

  genvar ep;
  generate
    for (ep = 0; ep < NUM_EP; ep++) begin : g_ep
      assign rd_txs[ep] = rd_go && (ra == TX_STATUS_ADDR + 8'(ep * 4));
      assign rd_rxs[ep] = rd_go && (ra == RX_STATUS_ADDR + 8'(ep * 4));
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          tx_q[ep]         <= 1'b0;
          tx_q[HI_BASE+ep] <= 1'b0;
          rx_q[ep]         <= 1'b0;
          rx_q[HI_BASE+ep] <= 1'b0;
          nak_q[ep]         <= 1'b0;
          nak_q[HI_BASE+ep] <= 1'b0;
        end else begin
          tx_q[ep] <= tx_done_i[ep] || (tx_q[ep] && !rd_txs[ep]); // [R11]
          if (ep == 0) begin
            tx_q[HI_BASE+ep] <= 1'b0; // [R13]
          end else begin
            tx_q[HI_BASE+ep] <= tx_underflow_i[ep] || (tx_q[HI_BASE+ep] && !rd_txs[ep]); // [R12]
          end
          if (ep == 0) begin
            rx_q[ep] <= rx_last_i[ep] || (rx_q[ep] && !rd_rxs[ep]); // [R16]
          end else begin
            rx_q[ep] <= rx_last_i[ep] || rx_err_i[ep] || (rx_q[ep] && !rd_rxs[ep]); // [R15]
          end
          rx_q[HI_BASE+ep] <= rx_overrun_i[ep] || (rx_q[HI_BASE+ep] && !rd_rx); // [R18]
          nak_q[ep] <= (nak_in_i[ep] && address_enable_i && endpoint_enable_i[ep])
                       || (nak_q[ep] && !rd_nak); // [R20]
          nak_q[HI_BASE+ep] <= (nak_out_i[ep] && !nak_out_overrun_i[ep] && address_enable_i
                                && endpoint_enable_i[ep]) || (nak_q[HI_BASE+ep] && !rd_nak); // [R21]
        end
      end
    end
  endgenerate
  logic misc_sum_q;
  logic nak_sum_q;
  logic tx_sum;
  logic rx_sum;
  logic [7:0] main_ev;

  // Miscellaneous summary keeps set priority over its clearing read; a NAK event read clears the NAK summary even when it sets
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      misc_sum_q <= 1'b0;
      nak_sum_q  <= 1'b0;
    end else begin
      misc_sum_q <= |(misc_set & misc_mask_q) || (misc_sum_q && !rd_misc); // [R10] [R23]
      nak_sum_q  <= (|(nak_q & nak_mask_q) || nak_sum_q) && !rd_nak; // [R22] [R24]
    end
  end

  // Transmit and receive summaries follow their flags directly
  assign tx_sum = |(tx_q & tx_mask_q); // [R14]
  assign rx_sum = |(rx_q & rx_mask_q); // [R19]
  always_comb begin
    main_ev = BYTE_ZERO;
    main_ev[MAIN_WARN] = other_main_events_i[0];
    main_ev[MAIN_MISC] = misc_sum_q || |(misc_view & misc_mask_q & ~MISC_COR_MASK);
    main_ev[MAIN_TX]   = tx_sum;
    main_ev[MAIN_SOF]  = other_main_events_i[1];
    main_ev[MAIN_NAK]  = nak_sum_q;
    main_ev[MAIN_LOCK] = other_main_events_i[2];
    main_ev[MAIN_RX]   = rx_sum;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_pin_o <= 1'b0;
    end else begin
      interrupt_pin_o <= main_mask_q[MAIN_MIE] && |(main_ev & main_mask_q); // [R25]
    end
  end
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = BYTE_ZERO;
    case (ra)
      MISC_EVENT_ADDR: rd_byte = misc_view;
      MISC_MASK_ADDR:  rd_byte = misc_mask_q;
      TX_EVENT_ADDR:   rd_byte = tx_q;
      TX_MASK_ADDR:    rd_byte = tx_mask_q;
      RX_EVENT_ADDR:   rd_byte = rx_q;
      RX_MASK_ADDR:    rd_byte = rx_mask_q;
      NAK_EVENT_ADDR:  rd_byte = nak_q;
      NAK_MASK_ADDR:   rd_byte = nak_mask_q;
      MAIN_EVENT_ADDR: rd_byte = main_ev;
      MAIN_MASK_ADDR:  rd_byte = main_mask_q;
      NODE_STATE_ADDR: rd_byte = {6'h00, node_state_q};
      default: begin
        rd_ok = (|rd_txs) || (|rd_rxs);
        rd_byte = BYTE_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_byte};
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// [unef_properties.sv]
// Checker: register bus handshakes and event flag read-back properties
`timescale 1ns/1ps
module unef_checker
  import unef_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        eop_valid_i,
  input wire logic        interrupt_pin_o
);
  logic [7:0] raddr_q;
  logic       eop_pend_q;
  logic       eop_exp_q;
  wire logic  ar_hs = s_axi_arvalid && s_axi_arready;
  wire logic  misc_rd = ar_hs && (s_axi_araddr == MISC_EVENT_ADDR);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) raddr_q <= 8'h00;
    else if (ar_hs) raddr_q <= s_axi_araddr;
  end

  // An end of packet in the reading cycle lands after the read, so it stays pending
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) eop_pend_q <= 1'b0;
    else if (misc_rd) eop_pend_q <= eop_valid_i;
    else if (eop_valid_i) eop_pend_q <= 1'b1;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) eop_exp_q <= 1'b0;
    else if (misc_rd) eop_exp_q <= eop_pend_q;
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  read_answer_a: assert property (ar_hs |=> s_axi_rvalid) else $error("read answer missing");
  rdata_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
  ep0_urun_a: assert property (s_axi_rvalid && raddr_q == TX_EVENT_ADDR |-> !s_axi_rdata[4])
    else $error("endpoint 0 underrun set");
  eop_flag_a: assert property (s_axi_rvalid && raddr_q == MISC_EVENT_ADDR |-> s_axi_rdata[3] == eop_exp_q)
    else $error("end of packet flag wrong");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
  bresp_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write accepted early");

  cover property (misc_rd);
  cover property ($rose(interrupt_pin_o));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind unef_top unef_checker i_checker (.*);

// [unef_bus_model.sv]
// Upstream bus line-state model: idle, single-ended zero or active signalling
`timescale 1ns/1ps
module unef_bus_model (
  input  wire logic       mclk_i,
  input  wire logic [1:0] line_cmd_i,
  output logic            bus_idle_o,
  output logic            bus_se0_o
);
  initial begin
    bus_idle_o = 1'b0;
    bus_se0_o  = 1'b0;
  end
  // Lines move off the clock edge, as an unrelated bus would
  always @(posedge mclk_i) begin
    bus_idle_o <= #7 (line_cmd_i == 2'h1);
    bus_se0_o  <= #7 (line_cmd_i == 2'h2);
  end
endmodule

// [test_usb_node_event_flags.sv]
// Testbench: event flags, masks and summaries through the register bus
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module test_usb_node_event_flags
  import unef_pkg::*;
;
  logic        mclk_i = 1'b0, rst_i = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        eop_valid_i = 1'b0, pending_wake_cpu_i = 1'b0, pending_wake_bus_i = 1'b0;
  logic [7:0]  dma_event_reg_i = 8'h00, dma_event_mask_i = 8'h00;
  logic [3:0]  tx_done_i = 4'h0, tx_underflow_i = 4'h0, rx_last_i = 4'h0, rx_err_i = 4'h0;
  logic [3:0]  rx_overrun_i = 4'h0, nak_in_i = 4'h0, nak_out_i = 4'h0, nak_out_overrun_i = 4'h0;
  logic        address_enable_i = 1'b0;
  logic [3:0]  endpoint_enable_i = 4'h0;
  logic [2:0]  other_main_events_i = 3'h0;
  logic [1:0]  line_cmd = 2'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        bus_idle_i, bus_se0_i, interrupt_pin_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, node_state_o;
  logic [31:0] s_axi_rdata;
  int          fail_count = 0, n_tests = 0;

  unef_top #(.SHORT_CYC(30), .LONG_CYC(50)) i_dut (.mclk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .bus_idle_i, .bus_se0_i, .eop_valid_i, .pending_wake_cpu_i, .pending_wake_bus_i,
    .dma_event_reg_i, .dma_event_mask_i, .tx_done_i, .tx_underflow_i, .rx_last_i, .rx_err_i, .rx_overrun_i,
    .nak_in_i, .nak_out_i, .nak_out_overrun_i, .address_enable_i, .endpoint_enable_i, .other_main_events_i,
    .node_state_o, .interrupt_pin_o);
  unef_bus_model i_bus (.mclk_i, .line_cmd_i(line_cmd), .bus_idle_o(bus_idle_i), .bus_se0_o(bus_se0_i));

  always #20 mclk_i = ~mclk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic cr(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, {24'h000000, e})
    `CHK(r, RESP_OKAY)
  endtask

  task automatic eop_pulse();
    @(posedge mclk_i);
    eop_valid_i <= 1'b1;
    @(posedge mclk_i);
    eop_valid_i <= 1'b0;
    tick(3);
  endtask

  task automatic t_reset_values();
    cr(MISC_MASK_ADDR, 8'h00);
    cr(TX_MASK_ADDR, 8'h00);
    cr(RX_MASK_ADDR, 8'h00);
    cr(NAK_MASK_ADDR, 8'h00);
    wr(TX_MASK_ADDR, 8'hA5, RESP_OKAY);
    cr(TX_MASK_ADDR, 8'hA5);
    wr(TX_MASK_ADDR, 8'h00, RESP_OKAY);
  endtask

  task automatic t_misc_events();
    wr(MAIN_MASK_ADDR, 8'h82, RESP_OKAY);
    eop_pulse();
    `CHK(interrupt_pin_o, 1'b0)
    cr(MISC_EVENT_ADDR, 8'h08);
    wr(MISC_MASK_ADDR, 8'h08, RESP_OKAY);
    eop_pulse();
    `CHK(interrupt_pin_o, 1'b1)
    cr(MISC_EVENT_ADDR, 8'h08);
    tick(2);
    `CHK(interrupt_pin_o, 1'b0)
    cr(MISC_EVENT_ADDR, 8'h00);
    wr(MAIN_MASK_ADDR, 8'h02, RESP_OKAY);
    eop_pulse();
    `CHK(interrupt_pin_o, 1'b0)
    cr(MISC_EVENT_ADDR, 8'h08);
  endtask

  task automatic t_line_timers();
    line_cmd <= 2'h1;
    tick(40);
    line_cmd <= 2'h0;
    cr(MISC_EVENT_ADDR, 8'h10);
    line_cmd <= 2'h1;
    tick(70);
    line_cmd <= 2'h0;
    cr(MISC_EVENT_ADDR, 8'h30);
    cr(MISC_EVENT_ADDR, 8'h00);
    line_cmd <= 2'h2;
    tick(80);
    line_cmd <= 2'h0;
    cr(MISC_EVENT_ADDR, 8'h40);
    wr(NODE_STATE_ADDR, {6'h00, NODE_RESET}, RESP_OKAY);
    tick(2500);
    wr(NODE_STATE_ADDR, 8'h02, RESP_OKAY);
    wr(NODE_STATE_ADDR, {6'h00, NODE_SUSPEND}, RESP_OKAY);
    `CHK(node_state_o, NODE_SUSPEND)
    tick(4);
    cr(MISC_EVENT_ADDR, 8'h80);
    wr(NODE_STATE_ADDR, 8'h02, RESP_OKAY);
    cr(MISC_EVENT_ADDR, 8'h80);
    cr(MISC_EVENT_ADDR, 8'h00);
  endtask

  task automatic t_wake_dma();
    pending_wake_cpu_i <= 1'b1;
    tick(3);
    cr(MISC_EVENT_ADDR, 8'h02);
    cr(MISC_EVENT_ADDR, 8'h02);
    pending_wake_cpu_i <= 1'b0;
    pending_wake_bus_i <= 1'b1;
    tick(3);
    cr(MISC_EVENT_ADDR, 8'h02);
    pending_wake_bus_i <= 1'b0;
    dma_event_reg_i <= 8'h10;
    dma_event_mask_i <= 8'h01;
    tick(3);
    cr(MISC_EVENT_ADDR, 8'h00);
    dma_event_mask_i <= 8'h10;
    tick(3);
    cr(MISC_EVENT_ADDR, 8'h04);
    dma_event_reg_i <= 8'h00;
    tick(3);
    cr(MISC_EVENT_ADDR, 8'h00);
  endtask

  task automatic t_tx_events();
    wr(MAIN_MASK_ADDR, 8'h84, RESP_OKAY);
    @(posedge mclk_i);
    tx_done_i <= 4'hF;
    tx_underflow_i <= 4'hF;
    @(posedge mclk_i);
    tx_done_i <= 4'h0;
    tx_underflow_i <= 4'h0;
    tick(3);
    cr(TX_EVENT_ADDR, 8'hEF);
    `CHK(interrupt_pin_o, 1'b0)
    wr(TX_MASK_ADDR, 8'h02, RESP_OKAY);
    tick(3);
    `CHK(interrupt_pin_o, 1'b1)
    cr(TX_STATUS_ADDR + 8'h04, 8'h00);
    cr(TX_EVENT_ADDR, 8'hCD);
    tick(2);
    `CHK(interrupt_pin_o, 1'b0)
  endtask

  task automatic t_rx_events();
    wr(MAIN_MASK_ADDR, 8'hC0, RESP_OKAY);
    wr(RX_MASK_ADDR, 8'h04, RESP_OKAY);
    @(posedge mclk_i);
    rx_err_i <= 4'h5;
    rx_last_i <= 4'h2;
    rx_overrun_i <= 4'h8;
    @(posedge mclk_i);
    rx_err_i <= 4'h0;
    rx_last_i <= 4'h0;
    rx_overrun_i <= 4'h0;
    tick(3);
    `CHK(interrupt_pin_o, 1'b1)
    cr(RX_EVENT_ADDR, 8'h86);
    cr(RX_EVENT_ADDR, 8'h06);
    cr(RX_STATUS_ADDR + 8'h08, 8'h00);
    tick(2);
    `CHK(interrupt_pin_o, 1'b0)
    cr(RX_EVENT_ADDR, 8'h02);
  endtask

  task automatic t_nak_events();
    wr(MAIN_MASK_ADDR, 8'h90, RESP_OKAY);
    wr(NAK_MASK_ADDR, 8'h01, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i);
      nak_in_i <= 4'hF;
      nak_out_i <= 4'hF;
      nak_out_overrun_i <= 4'h4;
      @(posedge mclk_i);
      nak_in_i <= 4'h0;
      nak_out_i <= 4'h0;
      nak_out_overrun_i <= 4'h0;
      address_enable_i <= 1'b1;
      endpoint_enable_i <= 4'h5;
      tick(3);
      if (i == 0) cr(NAK_EVENT_ADDR, 8'h00);
    end
    `CHK(interrupt_pin_o, 1'b1)
    cr(NAK_EVENT_ADDR, 8'h15);
    tick(2);
    `CHK(interrupt_pin_o, 1'b0)
    cr(NAK_EVENT_ADDR, 8'h00);
  endtask

  task automatic t_bus_errors();
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h80, 8'h01, RESP_SLVERR);
    wr(MAIN_EVENT_ADDR, 8'hFF, RESP_SLVERR);
    rd(8'h80, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h00000000)
  endtask

  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    tick(20);
    rst_i <= 1'b0;
    t_reset_values();
    t_misc_events();
    t_line_timers();
    t_wake_dma();
    t_tx_events();
    t_rx_events();
    t_nak_events();
    t_bus_errors();
    complete_run();
  end

  // Whole run needs about 3000 cycles; the 20000-cycle limit lies well beyond it
  initial begin
    tick(20000);
    fail_count++;
    complete_run();
  end
endmodule
